// ### design/nio_pkg.sv
package nio_pkg;

    // ------------------------------------------------------------------
    // AXI4-Lite register map
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] OUT_OFS = 8'h04;
    localparam logic [7:0] IN_OFS = 8'h08;
    localparam logic [7:0] BUS_OFS = 8'h0c;
    localparam logic [7:0] BDATA_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [7:0] HSDATA_OFS = 8'h18;

    // Mode register fields.
    localparam int LO_MODE_LSB = 0;
    localparam int HI_MODE_LSB = 2;
    localparam int OPEN_DRAIN_BIT = 4;
    localparam int LOW_EMI_BIT = 5;
    localparam int HANDSHAKE_BIT = 6;
    localparam int EXT_TIMING_BIT = 7;
    localparam int HIGHZ_BIT = 8;
    localparam int MODE_W = 9;

    // Nibble modes.
    localparam logic [1:0] NIB_OUT = 2'h0;
    localparam logic [1:0] NIB_IN = 2'h1;
    localparam logic [1:0] NIB_ADDR = 2'h2;

    // Reset values: external-program mode and internal-program mode.
    localparam logic [8:0] MODE_RST_EXT = 9'h08a;
    localparam logic [8:0] MODE_RST_INT = 9'h005;

    // Bus command register fields.
    localparam int BUS_WRITE_BIT = 16;
    localparam int BUS_START_BIT = 17;

    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_HSFULL_BIT = 1;

    // Timing: extended cycles add two clock periods.
    localparam int EXTRA_PERIODS = 2;
    localparam int AS_CYCLES = 2;
    localparam int DS_CYCLES = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : nio_pkg

// ### design/nio_bus_cycle.sv
`timescale 1ns/10ps
module nio_bus_cycle
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic extended,
    output logic address_strobe_n,
    output logic data_strobe_n,
    output logic busy,
    output logic done
);

    default clocking nio_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    typedef enum logic [1:0] {nio_idle, nio_as, nio_ds} nio_bus_st_t;
    nio_bus_st_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;

    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        done = 1'b0;
        case (st_reg)
            nio_idle:
            begin
                if (start)
                begin
                    st_next = nio_as;
                    cnt_next = 4'(nio_pkg::AS_CYCLES - 1);
                end
            end
            nio_as:
            begin
                if (cnt_reg == 4'h0)
                begin
                    st_next = nio_ds;
                    cnt_next = extended ?
                        4'(nio_pkg::DS_CYCLES + nio_pkg::EXTRA_PERIODS - 1) :
                        4'(nio_pkg::DS_CYCLES - 1);
                end
                else
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default:
            begin
                if (cnt_reg == 4'h0)
                begin
                    st_next = nio_idle;
                    done = 1'b1;
                end
                else
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= nio_idle;
            cnt_reg <= 4'h0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    // Address strobe first, data strobe after it ends.
    assign address_strobe_n = (st_reg != nio_as);
    assign data_strobe_n = (st_reg != nio_ds);
    assign busy = (st_reg != nio_idle);

    a_as_before_ds: assert property ($fell(data_strobe_n)
        |-> !$past(address_strobe_n))
        else $error("data strobe without preceding address strobe");
    a_ext_length: assert property ($fell(data_strobe_n) && extended
        |-> !data_strobe_n [*5] ##1 data_strobe_n)
        else $error("extended data strobe wrong length");
    a_norm_length: assert property ($fell(data_strobe_n) && !extended
        |-> !data_strobe_n [*3] ##1 data_strobe_n)
        else $error("normal data strobe wrong length");

endmodule : nio_bus_cycle

// ### design/nio_port.sv
// Function
// - Eight lines, nibble I/O or upper address.
// - Input direction chosen per nibble.
// - One global push-pull or open-drain select.
// - One global low-emission buffer select.
// - Two third-port lines act as handshake.
// - Handshake direction follows upper nibble.
// - Drive address 11:8 or 15:8 per mode.
// - Upper nibble usable as I/O with 12-bit addressing.
// - External-program reset: address 15:8, extended timing.
// - Software may cancel extended timing.
// - Extended cycles last two clocks longer.
// - Internal-program reset: all lines inputs.
// - High-impedance in address mode floats address nibbles, port one, strobes.
// - Lower handshake line input, higher output.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module nio_port
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic external_program_mode,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_zero_lines_in,
    output logic [7:0] port_zero_lines_out,
    output logic [7:0] port_zero_lines_oe,
    output logic low_emi,
    output logic port_one_float,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] lower_address_byte,
    output logic address_strobe_n,
    output logic address_strobe_n_oe,
    output logic data_strobe_n,
    output logic data_strobe_n_oe,
    output logic read_write,
    output logic read_write_oe,
    input wire logic handshake_input_line,
    output logic handshake_output_line
);

    default clocking nio_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [8:0] mode_reg, mode_next;
    logic [7:0] out_reg, out_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] wdat_reg, wdat_next;
    logic rw_reg, rw_next;
    logic [7:0] bdata_reg, bdata_next;
    logic [7:0] hs_reg, hs_next;
    logic hs_full_reg, hs_full_next;
    logic hs_in_q_reg, hs_in_q_next;
    logic boot_reg, boot_next;
    logic aw_reg, aw_next;
    logic [7:0] awa_reg, awa_next;
    logic w_reg, w_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic bv_reg, bv_next;
    logic [1:0] br_reg, br_next;
    logic rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0] rr_reg, rr_next;
    logic [7:0] pin_out_reg, pin_out_next;
    logic [7:0] pin_oe_reg, pin_oe_next;

    logic [1:0] lo_mode, hi_mode;
    logic hs_en, hs_out_dir, hi_z, bus_start, bus_busy, bus_done;
    logic do_write;
    logic [7:0] pin_val;

    assign lo_mode = mode_reg[nio_pkg::LO_MODE_LSB +: 2];
    assign hi_mode = mode_reg[nio_pkg::HI_MODE_LSB +: 2];
    assign hs_en = mode_reg[nio_pkg::HANDSHAKE_BIT];
    assign hs_out_dir = (hi_mode == nio_pkg::NIB_OUT);
    assign hi_z = mode_reg[nio_pkg::HIGHZ_BIT]
        && (lo_mode == nio_pkg::NIB_ADDR);
    assign low_emi = mode_reg[nio_pkg::LOW_EMI_BIT];

    // ------------------------------------------------------------------
    // External bus cycle sequencer
    // ------------------------------------------------------------------
    nio_bus_cycle u_cycle
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(bus_start),
        .extended(mode_reg[nio_pkg::EXT_TIMING_BIT]),
        .address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n),
        .busy(bus_busy),
        .done(bus_done)
    );

    // ------------------------------------------------------------------
    // Bus slave and port control
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_reg;
    assign s_axi_wready = !w_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rr_reg;
    assign do_write = aw_reg && w_reg && !bv_reg;

    always_comb
    begin
        mode_next = mode_reg;
        out_next = out_reg;
        addr_next = addr_reg;
        wdat_next = wdat_reg;
        rw_next = rw_reg;
        bdata_next = bdata_reg;
        hs_next = hs_reg;
        hs_full_next = hs_full_reg;
        hs_in_q_next = handshake_input_line;
        boot_next = 1'b0;
        aw_next = aw_reg;
        awa_next = awa_reg;
        w_next = w_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        bus_start = 1'b0;
        if (boot_reg)
        begin
            mode_next = external_program_mode ?
                nio_pkg::MODE_RST_EXT : nio_pkg::MODE_RST_INT;
        end
        if (bus_done && rw_reg)
        begin
            bdata_next = bus_data_in;
        end
        // Handshake: falling input edge strobes a byte.
        if (hs_en && hs_in_q_reg && !handshake_input_line)
        begin
            if (!hs_out_dir)
            begin
                hs_next = port_zero_lines_in;
                hs_full_next = 1'b1;
            end
            else
            begin
                hs_full_next = 1'b0;
            end
        end
        if (s_axi_awvalid && !aw_reg)
        begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !w_reg)
        begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = nio_pkg::RESP_OKAY;
            if (awa_reg == nio_pkg::MODE_OFS)
            begin
                if (ws_reg[0])
                begin
                    mode_next[7:0] = wd_reg[7:0];
                end
                if (ws_reg[1])
                begin
                    mode_next[nio_pkg::HIGHZ_BIT] = wd_reg[nio_pkg::HIGHZ_BIT];
                end
            end
            else if (awa_reg == nio_pkg::OUT_OFS)
            begin
                if (ws_reg[0])
                begin
                    out_next = wd_reg[7:0];
                    if (hs_en && hs_out_dir)
                    begin
                        hs_full_next = 1'b1;
                    end
                end
            end
            else if (awa_reg == nio_pkg::BUS_OFS)
            begin
                if (!bus_busy && ws_reg == 4'hf)
                begin
                    addr_next = wd_reg[15:0];
                    rw_next = !wd_reg[nio_pkg::BUS_WRITE_BIT];
                    wdat_next = wd_reg[31:24];
                    bus_start = wd_reg[nio_pkg::BUS_START_BIT];
                end
                else
                begin
                    br_next = nio_pkg::RESP_SLVERR;
                end
            end
            else
            begin
                br_next = nio_pkg::RESP_SLVERR;
            end
        end
        if (bv_reg && s_axi_bready)
        begin
            bv_next = 1'b0;
        end
        if (rv_reg && s_axi_rready)
        begin
            rv_next = 1'b0;
        end
        if (s_axi_arvalid && !rv_reg)
        begin
            rv_next = 1'b1;
            rr_next = nio_pkg::RESP_OKAY;
            rd_next = 32'h0;
            if (s_axi_araddr[7:0] == nio_pkg::MODE_OFS)
            begin
                rd_next[8:0] = mode_reg;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::OUT_OFS)
            begin
                rd_next[7:0] = out_reg;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::IN_OFS)
            begin
                rd_next[7:0] = port_zero_lines_in;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::BUS_OFS)
            begin
                rd_next[15:0] = addr_reg;
                rd_next[nio_pkg::BUS_WRITE_BIT] = !rw_reg;
                rd_next[31:24] = wdat_reg;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::BDATA_OFS)
            begin
                rd_next[7:0] = bdata_reg;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::STAT_OFS)
            begin
                rd_next[nio_pkg::ST_BUSY_BIT] = bus_busy;
                rd_next[nio_pkg::ST_HSFULL_BIT] = hs_full_reg;
            end
            else if (s_axi_araddr[7:0] == nio_pkg::HSDATA_OFS)
            begin
                rd_next[7:0] = hs_reg;
                // A byte arriving in the same cycle keeps the flag set.
                if (!hs_out_dir
                    && !(hs_en && hs_in_q_reg && !handshake_input_line))
                begin
                    hs_full_next = 1'b0;
                end
            end
            else
            begin
                rr_next = nio_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive per nibble
    // ------------------------------------------------------------------
    always_comb
    begin
        pin_val = out_reg;
        pin_oe_next = 8'h00;
        if (lo_mode == nio_pkg::NIB_ADDR)
        begin
            pin_val[3:0] = addr_reg[11:8];
            pin_oe_next[3:0] = 4'hf;
        end
        else if (lo_mode == nio_pkg::NIB_OUT)
        begin
            pin_oe_next[3:0] = 4'hf;
        end
        if (hi_mode == nio_pkg::NIB_ADDR && lo_mode == nio_pkg::NIB_ADDR)
        begin
            pin_val[7:4] = addr_reg[15:12];
            pin_oe_next[7:4] = 4'hf;
        end
        else if (hi_mode == nio_pkg::NIB_OUT)
        begin
            pin_oe_next[7:4] = 4'hf;
        end
        // Open drain drives only zeros.
        if (mode_reg[nio_pkg::OPEN_DRAIN_BIT])
        begin
            pin_oe_next = pin_oe_next & ~pin_val;
        end
        if (hi_z)
        begin
            pin_oe_next[3:0] = 4'h0;
            if (hi_mode == nio_pkg::NIB_ADDR)
            begin
                pin_oe_next[7:4] = 4'h0;
            end
        end
        pin_out_next = pin_val;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg <= nio_pkg::MODE_RST_INT;
            out_reg <= 8'h00;
            addr_reg <= 16'h0000;
            wdat_reg <= 8'h00;
            rw_reg <= 1'b1;
            bdata_reg <= 8'h00;
            hs_reg <= 8'h00;
            hs_full_reg <= 1'b0;
            hs_in_q_reg <= 1'b1;
            boot_reg <= 1'b1;
            aw_reg <= 1'b0;
            awa_reg <= 8'h00;
            w_reg <= 1'b0;
            wd_reg <= 32'h0;
            ws_reg <= 4'h0;
            bv_reg <= 1'b0;
            br_reg <= nio_pkg::RESP_OKAY;
            rv_reg <= 1'b0;
            rd_reg <= 32'h0;
            rr_reg <= nio_pkg::RESP_OKAY;
            pin_out_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
        end
        else
        begin
            mode_reg <= mode_next;
            out_reg <= out_next;
            addr_reg <= addr_next;
            wdat_reg <= wdat_next;
            rw_reg <= rw_next;
            bdata_reg <= bdata_next;
            hs_reg <= hs_next;
            hs_full_reg <= hs_full_next;
            hs_in_q_reg <= hs_in_q_next;
            boot_reg <= boot_next;
            aw_reg <= aw_next;
            awa_reg <= awa_next;
            w_reg <= w_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            rr_reg <= rr_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Write data of the external bus does not use this port.
    assign port_zero_lines_out = pin_out_reg;
    assign port_zero_lines_oe = pin_oe_reg;
    assign lower_address_byte = addr_reg[7:0];
    assign read_write = rw_reg;
    assign port_one_float = hi_z;
    assign address_strobe_n_oe = !hi_z;
    assign data_strobe_n_oe = !hi_z;
    assign read_write_oe = !hi_z;
    // Ready for a byte while the handshake buffer is not full.
    assign handshake_output_line = hs_en && !hs_full_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_boot_mode: assert property ($fell(boot_reg) |->
        mode_reg == (external_program_mode ? nio_pkg::MODE_RST_EXT
        : nio_pkg::MODE_RST_INT))
        else $error("reset mode does not follow program mode");
    a_int_inputs: assert property (lo_mode == nio_pkg::NIB_IN
        && hi_mode == nio_pkg::NIB_IN |=> port_zero_lines_oe == 8'h00)
        else $error("input port lines are driven");
    a_addr_drive: assert property (lo_mode == nio_pkg::NIB_ADDR && !hi_z
        |=> port_zero_lines_out[3:0] == $past(addr_reg[11:8]))
        else $error("address nibble not driven");
    a_open_drain: assert property (
        $past(mode_reg[nio_pkg::OPEN_DRAIN_BIT])
        |-> (port_zero_lines_oe & port_zero_lines_out) == 8'h00)
        else $error("open drain drives a high level");
    a_float_all: assert property (hi_z |-> !address_strobe_n_oe
        && !data_strobe_n_oe && !read_write_oe && port_one_float)
        else $error("high impedance incomplete");
    a_float_port: assert property ($past(hi_z)
        |-> port_zero_lines_oe[3:0] == 4'h0)
        else $error("address nibble driven while floating");
    a_hs_idle: assert property (!hs_en |-> !handshake_output_line)
        else $error("handshake output active while disabled");
    a_addr_stable: assert property (!data_strobe_n
        |=> $stable(addr_reg) && $stable(rw_reg))
        else $error("address moved during data strobe");
    a_emi_drive: assert property (
        low_emi == mode_reg[nio_pkg::LOW_EMI_BIT])
        else $error("low emission select lost");

    c_bus_cycle: cover property (@(posedge aclk) bus_done);
    c_hs_in: cover property (@(posedge aclk) hs_en && hs_full_reg);
    c_float: cover property (@(posedge aclk) hi_z);

endmodule : nio_port

// ### verification/nio_mem_model.sv
`timescale 1ns/10ps
module nio_mem_model
(
    input wire logic aclk,
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    input wire logic [7:0] addr_hi,
    input wire logic [7:0] addr_lo,
    output logic [7:0] bus_data_in,
    output logic [15:0] cap_addr,
    output logic [7:0] ds_width,
    output logic bus_ok
);
    logic [7:0] cnt_reg = 8'h00;
    logic [7:0] idle_reg = 8'h00;
    logic seen_reg = 1'h0;
    logic rw_reg = 1'h0;

    // Released data lines show a pattern that changes every cycle.
    assign bus_data_in = (data_strobe_n === 1'h0 && read_write === 1'h1) ?
        (cap_addr[7:0] ^ 8'h5a) : idle_reg;

    initial
    begin
        cap_addr = 16'h0000;
        ds_width = 8'h00;
        bus_ok = 1'h1;
    end

    always @(posedge aclk)
    begin
        idle_reg <= idle_reg + 8'h35;
        if (address_strobe_n === 1'h0)
        begin
            cap_addr <= {addr_hi, addr_lo};
            rw_reg <= read_write;
            seen_reg <= 1'h1;
        end
        if (data_strobe_n === 1'h0)
        begin
            cnt_reg <= cnt_reg + 8'h01;
            if (!seen_reg || {addr_hi, addr_lo} !== cap_addr)
                bus_ok <= 1'h0;
            if (read_write !== rw_reg)
                bus_ok <= 1'h0;
        end
        else if (cnt_reg != 8'h00)
        begin
            ds_width <= cnt_reg;
            cnt_reg <= 8'h00;
            seen_reg <= 1'h0;
        end
    end
endmodule : nio_mem_model

// ### verification/nibble_io_port_with_address_mode_tb_top.sv
`timescale 1ns/10ps
module nibble_io_port_with_address_mode_tb_top;
    logic aclk, aresetn, external_program_mode, s_axi_awvalid, s_axi_wvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_rready, handshake_input_line;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, low_emi, port_one_float, address_strobe_n;
    logic address_strobe_n_oe, data_strobe_n, data_strobe_n_oe, read_write;
    logic read_write_oe, handshake_output_line, bus_ok;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] port_zero_lines_in, port_zero_lines_out, port_zero_lines_oe;
    logic [7:0] bus_data_in, lower_address_byte, ds_width;
    logic [15:0] cap_addr;
    int err_total, check_count;

    nio_port u_nio_port
    (
        .aclk, .aresetn, .external_program_mode, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_zero_lines_in,
        .port_zero_lines_out, .port_zero_lines_oe, .low_emi, .port_one_float,
        .bus_data_in, .lower_address_byte, .address_strobe_n,
        .address_strobe_n_oe, .data_strobe_n, .data_strobe_n_oe, .read_write,
        .read_write_oe, .handshake_input_line, .handshake_output_line
    );

    nio_mem_model u_nio_mem_model
    (
        .aclk, .address_strobe_n, .data_strobe_n, .read_write,
        .addr_hi(port_zero_lines_out), .addr_lo(lower_address_byte),
        .bus_data_in, .cap_addr, .ds_width, .bus_ok
    );

    always #4 aclk = ~aclk;

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic time_out();
        err_total++;
        $display("wait limit reached at %0t", $time);
        complete_run();
    endtask : time_out

    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1 && n < 100);
        if (n >= 100)
            time_out();
        chk_val({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1 && n < 100);
        if (n >= 100)
            time_out();
        rd_data = s_axi_rdata;
        chk_val({30'h0, s_axi_rresp}, {30'h0, nio_pkg::RESP_OKAY});
    endtask : rd

    task automatic bus_go(input logic [31:0] cmd);
        int n;
        n = 0;
        wr(nio_pkg::BUS_OFS, cmd, nio_pkg::RESP_OKAY);
        do
        begin
            rd(nio_pkg::STAT_OFS);
            n++;
        end
        while (rd_data[nio_pkg::ST_BUSY_BIT] !== 1'h0 && n < 50);
        if (n >= 50)
            time_out();
    endtask : bus_go

    task automatic do_reset(input logic strap);
        aresetn <= 1'h0;
        external_program_mode <= strap;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
    endtask : do_reset

    task automatic mode(input logic [31:0] m);
        wr(nio_pkg::MODE_OFS, m, nio_pkg::RESP_OKAY);
        settle();
    endtask : mode

    task automatic hs_pulse();
        handshake_input_line <= 1'h0;
        settle();
        handshake_input_line <= 1'h1;
        settle();
    endtask : hs_pulse

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {aclk, aresetn, external_program_mode, s_axi_awvalid} = 4'h0;
        {s_axi_wvalid, s_axi_arvalid} = 2'h0;
        {s_axi_bready, s_axi_rready, handshake_input_line} = 3'h7;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hf;
        port_zero_lines_in = 8'h3c;
        err_total = 0;
        check_count = 0;
        do_reset(1'h0);
        rd(nio_pkg::MODE_OFS);
        chk_val(rd_data, {23'h0, nio_pkg::MODE_RST_INT});
        chk_val({24'h0, port_zero_lines_oe}, 32'h00);
        mode(32'h000);
        wr(nio_pkg::OUT_OFS, 32'ha5, nio_pkg::RESP_OKAY);
        settle();
        chk_val({24'h0, port_zero_lines_out}, 32'ha5);
        chk_val({24'h0, port_zero_lines_oe}, 32'hff);
        mode(32'h004);
        chk_val({24'h0, port_zero_lines_oe}, 32'h0f);
        mode(32'h034);
        chk_val({24'h0, port_zero_lines_oe}, 32'h0a);
        chk_val({31'h0, low_emi}, 32'h1);
        mode(32'h005);
        chk_val({31'h0, low_emi}, 32'h0);
        rd(nio_pkg::IN_OFS);
        chk_val(rd_data, 32'h3c);
        wr(8'h40, 32'h0, nio_pkg::RESP_SLVERR);
        $display("test general io done at %0t", $time);
        port_zero_lines_in <= 8'h77;
        mode(32'h045);
        chk_val({31'h0, handshake_output_line}, 32'h1);
        hs_pulse();
        chk_val({31'h0, handshake_output_line}, 32'h0);
        rd(nio_pkg::HSDATA_OFS);
        chk_val(rd_data, 32'h77);
        settle();
        chk_val({31'h0, handshake_output_line}, 32'h1);
        mode(32'h040);
        wr(nio_pkg::OUT_OFS, 32'h99, nio_pkg::RESP_OKAY);
        settle();
        chk_val({31'h0, handshake_output_line}, 32'h0);
        hs_pulse();
        chk_val({31'h0, handshake_output_line}, 32'h1);
        $display("test handshake done at %0t", $time);
        do_reset(1'h1);
        rd(nio_pkg::MODE_OFS);
        chk_val(rd_data, {23'h0, nio_pkg::MODE_RST_EXT});
        chk_val({24'h0, port_zero_lines_oe}, 32'hff);
        bus_go(32'h00021234);
        chk_val({16'h0, cap_addr}, 32'h1234);
        chk_val({24'h0, ds_width},
            nio_pkg::DS_CYCLES + nio_pkg::EXTRA_PERIODS);
        rd(nio_pkg::BDATA_OFS);
        chk_val(rd_data, 32'h6e);
        mode(32'h00a);
        bus_go(32'hc5031234);
        chk_val({24'h0, ds_width}, nio_pkg::DS_CYCLES);
        rd(nio_pkg::BUS_OFS);
        chk_val(rd_data, 32'hc5011234);
        wr(nio_pkg::OUT_OFS, 32'h50, nio_pkg::RESP_OKAY);
        mode(32'h002);
        bus_go(32'h00020abc);
        chk_val({16'h0, cap_addr}, 32'h5abc);
        chk_val({31'h0, bus_ok}, 32'h1);
        mode(32'h10a);
        chk_val({28'h0, address_strobe_n_oe, data_strobe_n_oe, read_write_oe,
            port_one_float}, 32'h1);
        chk_val({24'h0, port_zero_lines_oe}, 32'h00);
        $display("test external bus done at %0t", $time);
        complete_run();
    end
endmodule : nibble_io_port_with_address_mode_tb_top
